/* File: logic/dpc_ctrl.sv */
// Controller driving clock enable, termination and commands of a DDR2 memory
`timescale 1ns/1ps
module dpc_ctrl
  import dpc_pkg::*;
#(
  parameter int PD_MAX_CLK = DPC_PD_MAX_CLK
)(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Software register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Link clock from the bench
  input  wire logic        mem_clk,
  // Memory pins
  output logic             cke,
  output logic             termination_control,
  output logic [3:0]       mem_cmd,
  output logic [15:0]      mem_addr
);
  initial begin
    if (PD_MAX_CLK < DPC_CKE_HOLD_CLK) $error("PD_MAX_CLK too small");
  end

  typedef enum {
    ST_IDLE, ST_ISSUE, ST_ENTRY_WAIT, ST_PD, ST_SR, ST_FREQ, ST_EXIT_HOLD, ST_SR_NOP, ST_RELOCK
  } dpc_state_t;

  logic              clk_rise;
  dpc_state_t        st_q, st_d;
  logic              cke_q, cke_d;
  logic              odt_q, odt_d;
  logic [3:0]        cmd_q, cmd_d;
  logic [15:0]       addr_q, addr_d;
  logic [8:0]        hold_q, hold_d;   // Clocks since last clock enable change
  logic [15:0]       wait_q, wait_d;   // General wait counter
  logic [15:0]       dwell_q, dwell_d; // Power-down dwell counter
  logic [2:0]        req_q, req_d;
  logic              go_q, go_d;
  logic              odt_en_q, odt_en_d;
  logic              odt_lvl_q, odt_lvl_d;
  logic              bank_act_q, bank_act_d;
  logic              cgo_q, cgo_d;
  logic [3:0]        ccmd_q, ccmd_d;
  logic [15:0]       mode_q, mode_d;
  logic              freq_q, freq_d;
  logic              newclk_q, newclk_d;
  logic              busy_q, busy_d;
  logic [31:0]       rdata_q, rdata_d;

  dpc_edge_sync u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in (mem_clk),
    .rise     (clk_rise)
  );

  // Write recovery count from mode bits 9..11, coded value plus one
  function automatic logic [15:0] wr_clocks(input logic [15:0] m);
    wr_clocks = {13'h0000, m[DPC_MODE_WR_LSB +: 3]} + 16'h0001;
  endfunction : wr_clocks

  // Entry gap required after a command before clock enable may fall
  function automatic logic [15:0] entry_gap(input logic [3:0] c, input logic [15:0] m);
    case (c)
      DPC_CMD_RD:  entry_gap = 16'h0005;
      DPC_CMD_WR:  entry_gap = 16'h0005 + wr_clocks(m);
      DPC_CMD_LMR: entry_gap = 16'(DPC_MRD_CLK);
      default:     entry_gap = 16'(DPC_ENTRY_GAP_CLK);
    endcase
  endfunction : entry_gap

  // Register port decode and software fields
  always_comb begin
    go_d       = 1'b0;
    cgo_d      = 1'b0;
    req_d      = req_q;
    odt_en_d   = odt_en_q;
    odt_lvl_d  = odt_lvl_q;
    bank_act_d = bank_act_q;
    ccmd_d     = ccmd_q;
    mode_d     = mode_q;
    newclk_d   = newclk_q;
    rdata_d    = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        DPC_REG_CTRL: begin
          go_d       = reg_wdata[DPC_CTRL_GO];
          req_d      = reg_wdata[DPC_CTRL_REQ_LSB +: 3];
          odt_en_d   = reg_wdata[DPC_CTRL_ODT_EN];
          odt_lvl_d  = reg_wdata[DPC_CTRL_ODT_LVL];
          bank_act_d = reg_wdata[DPC_CTRL_BANK_ACT];
          newclk_d   = reg_wdata[7];
        end
        DPC_REG_CMD: begin
          cgo_d  = reg_wdata[DPC_CMD_GO];
          ccmd_d = reg_wdata[DPC_CMD_LSB +: 4];
        end
        DPC_REG_MODE: mode_d = reg_wdata[15:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        DPC_REG_CTRL:   rdata_d = {24'h000000, newclk_q, bank_act_q, odt_lvl_q, odt_en_q, req_q, 1'b0};
        DPC_REG_STATUS: rdata_d = {16'h0000, freq_q, busy_q, cke_q, odt_q, 8'(st_q), 4'h0};
        DPC_REG_CMD:    rdata_d = {27'h0000000, ccmd_q, 1'b0};
        DPC_REG_MODE:   rdata_d = {16'h0000, mode_q};
        default:        rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Power-state sequencer; all pin changes happen on link clock rising edges
  always_comb begin
    st_d    = st_q;
    cke_d   = cke_q;
    odt_d   = odt_q;
    cmd_d   = cmd_q;
    addr_d  = addr_q;
    hold_d  = hold_q;
    wait_d  = wait_q;
    dwell_d = dwell_q;
    freq_d  = freq_q;
    busy_d  = (st_q != ST_IDLE) | go_q | cgo_q;
    if (clk_rise) begin
      if (hold_q != 9'h1ff) hold_d = hold_q + 9'h001;
      if (wait_q != 16'h0000) wait_d = wait_q - 16'h0001;
      cmd_d = DPC_CMD_NOP;
      case (st_q)
        ST_IDLE: begin
          odt_d = odt_en_q & odt_lvl_q;
          if (cgo_q | go_q) st_d = ST_ISSUE;
        end
        ST_ISSUE: begin
          if (ccmd_valid()) begin
            cmd_d  = ccmd_q;
            addr_d = (ccmd_q == DPC_CMD_LMR) ? mode_q : 16'h0400;
            wait_d = entry_gap(ccmd_q, mode_q);
          end
          st_d = (req_q == DPC_REQ_NONE) ? ST_IDLE : ST_ENTRY_WAIT;
        end
        ST_ENTRY_WAIT: begin
          if (wait_q == 16'h0000 && hold_q >= 9'(DPC_CKE_HOLD_CLK)) begin
            if (req_q == DPC_REQ_SR && !bank_act_q) begin
              cmd_d = DPC_CMD_REF;
              odt_d = 1'b0;
              st_d  = ST_SR;
            end else if (req_q == DPC_REQ_FREQ && !bank_act_q) begin
              odt_d  = 1'b0;
              wait_d = 16'(DPC_FREQ_WAIT_CLK);
              st_d   = ST_FREQ;
            end else if (req_q == DPC_REQ_PD) begin
              st_d = ST_PD;
            end else begin
              st_d = ST_IDLE;
            end
            if (st_d != ST_IDLE) begin
              cke_d   = 1'b0;
              hold_d  = 9'h000;
              dwell_d = 16'h0000;
            end
          end
        end
        ST_PD: begin
          odt_d   = odt_en_q & odt_lvl_q;
          dwell_d = dwell_q + 16'h0001;
          if (hold_q >= 9'(DPC_CKE_HOLD_CLK) &&
              (req_q == DPC_REQ_EXIT || dwell_q >= 16'(PD_MAX_CLK))) begin
            cke_d  = 1'b1;
            hold_d = 9'h000;
            wait_d = mode_q[DPC_MODE_PD_EXIT] ? 16'h0006 : 16'h0002;
            st_d   = ST_EXIT_HOLD;
          end
        end
        ST_SR: begin
          odt_d = 1'b0;
          if (hold_q >= 9'(DPC_CKE_HOLD_CLK) && req_q == DPC_REQ_EXIT) begin
            cke_d  = 1'b1;
            hold_d = 9'h000;
            wait_d = 16'(DPC_SR_READ_CLK);
            st_d   = ST_SR_NOP;
          end
        end
        ST_FREQ: begin
          odt_d = 1'b0;
          freq_d = (wait_q == 16'h0000);
          if (freq_q && newclk_q && hold_q >= 9'(DPC_CKE_HOLD_CLK + DPC_NEWCLK_CLK)) begin
            cke_d  = 1'b1;
            hold_d = 9'h000;
            freq_d = 1'b0;
            wait_d = 16'(DPC_DLL_RELOCK_CLK);
            st_d   = ST_RELOCK;
          end
        end
        ST_EXIT_HOLD: if (wait_q == 16'h0000 && hold_q >= 9'(DPC_CKE_HOLD_CLK)) st_d = ST_IDLE;
        ST_SR_NOP: begin
          odt_d = 1'b0;
          if (wait_q == 16'h0000) st_d = ST_IDLE;
        end
        ST_RELOCK: begin
          odt_d = 1'b0;
          if (wait_q == 16'(DPC_DLL_RELOCK_CLK)) begin
            cmd_d  = DPC_CMD_LMR;
            addr_d = mode_q | 16'h0100;
          end
          if (wait_q == 16'h0000) st_d = ST_IDLE;
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // A software command is valid whenever its go flag is pending; the issue state sends it
  function automatic logic ccmd_valid();
    ccmd_valid = cgo_q;
  endfunction : ccmd_valid

  // Registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q       <= ST_IDLE;
      cke_q      <= 1'b1;
      odt_q      <= 1'b0;
      cmd_q      <= DPC_CMD_NOP;
      addr_q     <= 16'h0000;
      hold_q     <= 9'h000;
      wait_q     <= 16'h0000;
      dwell_q    <= 16'h0000;
      req_q      <= 3'h0;
      go_q       <= 1'b0;
      odt_en_q   <= 1'b0;
      odt_lvl_q  <= 1'b0;
      bank_act_q <= 1'b0;
      cgo_q      <= 1'b0;
      ccmd_q     <= DPC_CMD_NOP;
      mode_q     <= DPC_MODE_RST;
      freq_q     <= 1'b0;
      newclk_q   <= 1'b0;
      busy_q     <= 1'b0;
      rdata_q    <= 32'h0000_0000;
    end else begin
      st_q       <= st_d;
      cke_q      <= cke_d;
      odt_q      <= odt_d;
      cmd_q      <= cmd_d;
      addr_q     <= addr_d;
      hold_q     <= hold_d;
      wait_q     <= wait_d;
      dwell_q    <= dwell_d;
      req_q      <= req_d;
      go_q       <= go_d | (go_q & ~(clk_rise & st_q == ST_IDLE));
      odt_en_q   <= odt_en_d;
      odt_lvl_q  <= odt_lvl_d;
      bank_act_q <= bank_act_d;
      cgo_q      <= cgo_d | (cgo_q & ~(clk_rise & st_q == ST_ISSUE));
      ccmd_q     <= ccmd_d;
      mode_q     <= mode_d;
      freq_q     <= freq_d;
      newclk_q   <= newclk_d;
      busy_q     <= busy_d;
      rdata_q    <= rdata_d;
    end
  end

  assign cke                 = cke_q;
  assign termination_control = odt_q;
  assign mem_cmd             = cmd_q;
  assign mem_addr            = addr_q;
  assign reg_rdata           = rdata_q;

  // Clock enable changes only after three link edges at the old level
  AST_CKE_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $changed(cke_q) |-> hold_q == 9'h000)
    else $error("clock enable hold reset missing");
  // Entry and exit of power-down carry only NOP
  AST_ENTRY_NOP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(cke_q) && st_q == ST_PD |-> cmd_q == DPC_CMD_NOP)
    else $error("power-down entry without NOP");
  AST_SR_REF: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(cke_q) && st_q == ST_SR |-> cmd_q == DPC_CMD_REF && !bank_act_q)
    else $error("self refresh entry without REFRESH");
  AST_SR_EXIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(cke_q) && st_q == ST_SR_NOP |-> cmd_q == DPC_CMD_NOP)
    else $error("self refresh exit without NOP");
  AST_SR_ODT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == ST_SR |-> !odt_q)
    else $error("termination on in self refresh");
  AST_FREQ_LOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == ST_FREQ |-> !cke_q && !odt_q)
    else $error("pins moved during frequency change");
  AST_RELOCK_ODT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == ST_RELOCK |-> !odt_q && cke_q)
    else $error("termination on during relock");
  AST_PD_LIMIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == ST_PD |-> dwell_q <= 16'(PD_MAX_CLK) + 16'h0001)
    else $error("power-down too long");
  // Power-down exit is a two-step move: leave the dwell state, then hold
  sequence s_pd_exit;
    st_q == ST_PD ##1 st_q == ST_EXIT_HOLD;
  endsequence
  AST_PD_EXIT_NOP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_pd_exit |-> cmd_q == DPC_CMD_NOP && cke_q)
    else $error("power-down exit without NOP");
  // Only NOPs go out while the memory settles after self refresh
  AST_SR_NOP_CMD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == ST_SR_NOP |-> cmd_q == DPC_CMD_NOP)
    else $error("command during self refresh exit delay");
endmodule : dpc_ctrl

/* File: logic/dpc_pkg.sv */
// Package with constants and types for the power-state controller
package dpc_pkg;
  // Register offsets of the controller's own register file (byte addresses)
  localparam logic [7:0] DPC_REG_CTRL   = 8'h00;
  localparam logic [7:0] DPC_REG_STATUS = 8'h04;
  localparam logic [7:0] DPC_REG_CMD    = 8'h08;
  localparam logic [7:0] DPC_REG_MODE   = 8'h0c;
  // Field positions in the control register
  localparam int DPC_CTRL_GO       = 0;
  localparam int DPC_CTRL_REQ_LSB  = 1;
  localparam int DPC_CTRL_ODT_EN   = 4;
  localparam int DPC_CTRL_ODT_LVL  = 5;
  localparam int DPC_CTRL_BANK_ACT = 6;
  // Field positions in the command register
  localparam int DPC_CMD_GO   = 0;
  localparam int DPC_CMD_LSB  = 1;
  // Mode register field positions
  localparam int DPC_MODE_WR_LSB = 9;
  localparam int DPC_MODE_PD_EXIT = 12;
  // Reset values
  localparam logic [31:0] DPC_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] DPC_MODE_RST = 16'h0000;
  // Timing counts in link clocks
  localparam int DPC_CKE_HOLD_CLK   = 3;
  localparam int DPC_SR_READ_CLK    = 200;
  localparam int DPC_DLL_RELOCK_CLK = 200;
  localparam int DPC_FREQ_WAIT_CLK  = 2;
  localparam int DPC_NEWCLK_CLK     = 1;
  localparam int DPC_ENTRY_GAP_CLK  = 1;
  localparam int DPC_MRD_CLK        = 2;
  // Default longest power-down dwell before forced exit, in link clocks
  localparam int DPC_PD_MAX_CLK     = 1000;
  // Command codes: cs_n, ras_n, cas_n, we_n
  localparam logic [3:0] DPC_CMD_NOP  = 4'h7;
  localparam logic [3:0] DPC_CMD_DES  = 4'hf;
  localparam logic [3:0] DPC_CMD_REF  = 4'h1;
  localparam logic [3:0] DPC_CMD_PRE  = 4'h2;
  localparam logic [3:0] DPC_CMD_ACT  = 4'h3;
  localparam logic [3:0] DPC_CMD_RD   = 4'h5;
  localparam logic [3:0] DPC_CMD_WR   = 4'h4;
  localparam logic [3:0] DPC_CMD_LMR  = 4'h0;
  // Requests from software
  typedef enum logic [2:0] {
    DPC_REQ_NONE, DPC_REQ_PD, DPC_REQ_SR, DPC_REQ_EXIT, DPC_REQ_FREQ
  } dpc_req_t;
endpackage : dpc_pkg

/* File: logic/dpc_edge_sync.sv */
// Two-stage synchroniser with rising edge detector for the link clock
`timescale 1ns/1ps
module dpc_edge_sync
  import dpc_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Asynchronous input and its rising edge
  input  wire logic async_in,
  output logic      rise
);
  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;

  // Next values; the second and third stages feed the edge detector
  always_comb begin
    s1_d = async_in;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign rise = s2_q & ~s3_q;
endmodule : dpc_edge_sync

/* File: testbench/dpc_dram_model.sv */
// Behavioural model of the memory's clock-enable power-state logic
`timescale 1ns/1ps
module dpc_dram_model
  import dpc_pkg::*;
(
  // Link clock and power-up reset
  input  wire logic       mem_clk,
  input  wire logic       rst,
  // Pins from the controller
  input  wire logic       cke,
  input  wire logic       termination_control,
  input  wire logic [3:0] mem_cmd,
  // Observed state and count of illegal sequences
  output logic      [2:0] st,
  output logic      [7:0] viol
);
  logic cke_prev;
  int   hold;
  int   since_sr;
  logic nop_like;

  // Deselect has chip select high whatever the other lines show
  assign nop_like = mem_cmd[3] || (mem_cmd == DPC_CMD_NOP);

  // State decided at each link edge from previous and current clock enable
  always @(posedge mem_clk or posedge rst) begin
    int v;
    v = 0;
    if (rst) begin
      st       <= 3'h0;
      cke_prev <= 1'b1;
      hold     <= DPC_CKE_HOLD_CLK;
      since_sr <= 1000;
      viol     <= 8'h00;
    end else begin
      cke_prev <= cke;
      since_sr <= since_sr + 1;
      hold     <= (cke != cke_prev) ? 1 : hold + 1;
      if (cke != cke_prev && hold < DPC_CKE_HOLD_CLK) v++;
      if (st == 3'h4 && termination_control) v++;
      if (cke_prev && !cke) begin
        if (nop_like && st < 3'h2) st <= (st == 3'h1) ? 3'h3 : 3'h2;
        else if (mem_cmd == DPC_CMD_REF && st == 3'h0) st <= 3'h4;
        else v++;
      end else if (!cke_prev && cke) begin
        if (!nop_like) v++;
        st <= (st == 3'h3) ? 3'h1 : 3'h0;
        if (st == 3'h4) since_sr <= 0;
      end else if (cke) begin
        // Commands other than NOP or deselect within DPC_SR_READ_CLK link edges of self refresh exit are flagged
        if (!nop_like && since_sr < DPC_SR_READ_CLK) v++;
        if (mem_cmd == DPC_CMD_ACT) st <= 3'h1;
        if (mem_cmd == DPC_CMD_PRE) st <= 3'h0;
        if (mem_cmd == DPC_CMD_REF && st != 3'h0) v++;
      end
      viol <= viol + 8'(v);
    end
  end
endmodule : dpc_dram_model

/* File: testbench/tb.sv */
// Self-checking bench for the clock-enable power-state controller
`timescale 1ns/1ps
module tb;
  import dpc_pkg::*;
  localparam int PD_MAX = 20;
  localparam int LCK    = 16;    // System clocks per link clock
  localparam int LIMIT  = 40000; // Whole run stays well below this
  localparam logic [2:0] S_IDLE = 3'h0;
  localparam logic [2:0] S_ACT  = 3'h1;
  localparam logic [2:0] S_PPD  = 3'h2;
  localparam logic [2:0] S_APD  = 3'h3;
  localparam logic [2:0] S_SR   = 3'h4;
  localparam logic [31:0] BANK  = 32'h1 << DPC_CTRL_BANK_ACT;
  localparam logic [31:0] TERMINATION_CONTROL   = (32'h1 << DPC_CTRL_ODT_EN) | (32'h1 << DPC_CTRL_ODT_LVL);
  logic        sys_clk;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        mem_clk;
  logic        cke;
  logic        termination_control;
  logic [3:0]  mem_cmd;
  logic [15:0] mem_addr;
  logic [2:0]  st;
  logic [7:0]  viol;
  int          fails;
  int          num_checks;
  int          cycles;

  dpc_ctrl #(.PD_MAX_CLK(PD_MAX)) dpc_ctrl_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_clk(mem_clk), .cke(cke),
    .termination_control(termination_control), .mem_cmd(mem_cmd), .mem_addr(mem_addr));

  dpc_dram_model dpc_dram_model_inst (
    .mem_clk(mem_clk), .rst(sys_rst), .cke(cke), .termination_control(termination_control),
    .mem_cmd(mem_cmd), .st(st), .viol(viol));

  // System clock
  always #5 sys_clk = ~sys_clk;

  // Link clock, phase unrelated to the system clock
  initial begin
    mem_clk = 1'b0;
    #37;
    forever #80 mem_clk = ~mem_clk;
  end

  // Hang guard: a run that overstays counts as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      $display("[ERR] %0t run did not finish in time", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic links(input int n);
    repeat (n * LCK) @(posedge sys_clk);
  endtask : links

  task automatic wait_cke(input logic lvl, input int lim);
    int n;
    n = 0;
    while (cke !== lvl && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_cke

  task automatic request(input dpc_req_t r, input logic [31:0] extra);
    wr(DPC_REG_CTRL, extra | (32'(r) << DPC_CTRL_REQ_LSB) | 32'h1);
  endtask : request

  task automatic command(input logic [3:0] c);
    wr(DPC_REG_CMD, (32'(c) << DPC_CMD_LSB) | 32'h1);
  endtask : command

  task automatic t_reset();
    logic [31:0] d;
    rd(DPC_REG_CTRL, d);
    chk(d, DPC_CTRL_RST, "control after reset");
    rd(8'h10, d);
    chk(d, 32'h0, "unmapped read");
    wr(DPC_REG_MODE, 32'h1000);
    rd(DPC_REG_MODE, d);
    chk(d, 32'h1000, "mode readback");
    chk(32'(cke), 32'h1, "cke after reset");
    chk(32'(mem_cmd), 32'(DPC_CMD_NOP), "idle command");
    $display("test reset done");
  endtask : t_reset

  task automatic t_apd();
    command(DPC_CMD_ACT);
    request(DPC_REQ_PD, BANK);
    wait_cke(1'b0, 40 * LCK);
    links(2);
    chk(32'(st), 32'(S_APD), "active power-down");
    request(DPC_REQ_EXIT, BANK);
    wait_cke(1'b1, 20 * LCK);
    links(1);
    chk(32'(st), 32'(S_ACT), "active power-down exit");
    $display("test active power-down done");
  endtask : t_apd

  task automatic t_ppd();
    logic [31:0] d;
    command(DPC_CMD_PRE);
    request(DPC_REQ_PD, 32'h0);
    wait_cke(1'b0, 40 * LCK);
    links(2);
    chk(32'(st), 32'(S_PPD), "precharge power-down");
    rd(DPC_REG_STATUS, d);
    chk(32'(d[13]), 32'h0, "status cke");
    request(DPC_REQ_EXIT, 32'h0);
    wait_cke(1'b1, 20 * LCK);
    links(1);
    chk(32'(st), 32'(S_IDLE), "precharge power-down exit");
    $display("test precharge power-down done");
  endtask : t_ppd

  // Entry must wait out the gap behind a read or load-mode command
  task automatic t_gap(input logic [3:0] c, input int gap);
    int n;
    n = 0;
    command(c);
    request(DPC_REQ_PD, 32'h0);
    while (mem_cmd !== c && n < 40 * LCK) begin
      @(posedge sys_clk);
      n++;
    end
    links(gap);
    chk(32'(cke), 32'h1, "no entry inside command gap");
    wait_cke(1'b0, 40 * LCK);
    links(1);
    chk(32'(st), 32'(S_PPD), "entry after command gap");
    request(DPC_REQ_EXIT, 32'h0);
    wait_cke(1'b1, 20 * LCK);
    links(4);
    $display("test command gap done");
  endtask : t_gap

  task automatic t_sr();
    request(DPC_REQ_SR, 32'h0);
    wait_cke(1'b0, 40 * LCK);
    links(2);
    chk(32'(st), 32'(S_SR), "self refresh entry");
    chk(32'(termination_control), 32'h0, "termination in self refresh");
    request(DPC_REQ_EXIT, 32'h0);
    wait_cke(1'b1, 20 * LCK);
    links(DPC_SR_READ_CLK + 5);
    chk(32'(st), 32'(S_IDLE), "self refresh exit");
    chk(32'(viol), 32'h0, "commands after self refresh");
    $display("test self refresh done");
  endtask : t_sr

  task automatic t_refuse();
    request(DPC_REQ_SR, BANK);
    links(10);
    chk(32'(cke), 32'h1, "self refresh with bank open");
    request(DPC_REQ_FREQ, BANK);
    links(10);
    chk(32'(cke), 32'h1, "frequency change with bank open");
    $display("test refusals done");
  endtask : t_refuse

  task automatic t_odt_dwell();
    request(DPC_REQ_PD, TERMINATION_CONTROL);
    wait_cke(1'b0, 40 * LCK);
    links(1);
    chk(32'(termination_control), 32'h1, "termination level in power-down");
    request(DPC_REQ_NONE, 32'h0);
    wait_cke(1'b1, (PD_MAX + 10) * LCK);
    chk(32'(cke), 32'h1, "bounded power-down dwell");
    links(4);
    chk(32'(viol), 32'h0, "clean dwell exit");
    $display("test termination and dwell done");
  endtask : t_odt_dwell

  task automatic t_freq();
    logic [31:0] d;
    logic        bad;
    logic        seen_lm;
    logic [15:0] lm_addr;
    bad = 1'b0;
    seen_lm = 1'b0;
    lm_addr = 16'h0000;
    request(DPC_REQ_FREQ, TERMINATION_CONTROL);
    wait_cke(1'b0, 40 * LCK);
    links(DPC_FREQ_WAIT_CLK + 1);
    rd(DPC_REG_STATUS, d);
    chk(32'(d[15]), 32'h1, "frequency window open");
    chk(32'(st), 32'(S_PPD), "frequency change from precharge power-down");
    chk(32'(termination_control), 32'h0, "termination during change");
    links(2);
    chk(32'(cke), 32'h0, "clock enable low until new clock");
    request(DPC_REQ_EXIT, TERMINATION_CONTROL | 32'h80);
    wait_cke(1'b1, 20 * LCK);
    // Termination stays off for the relock period although it is enabled
    repeat ((DPC_DLL_RELOCK_CLK - 2) * LCK) begin
      @(posedge sys_clk);
      if (termination_control !== 1'b0) bad = 1'b1;
      if (mem_cmd === DPC_CMD_LMR) begin
        seen_lm = 1'b1;
        lm_addr = mem_addr;
      end
    end
    chk(32'(bad), 32'h0, "termination during relock");
    chk(32'(seen_lm), 32'h1, "mode load after new clock");
    chk(32'(lm_addr[DPC_MODE_PD_EXIT]), 32'h1, "mode load carries mode value");
    $display("test frequency change done");
  endtask : t_freq

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    sys_clk   = 1'b0;
    sys_rst   = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_apd();
    t_ppd();
    t_gap(DPC_CMD_RD, 4);
    t_gap(DPC_CMD_LMR, 1);
    t_sr();
    t_refuse();
    t_odt_dwell();
    t_freq();
    wrap_up();
  end
endmodule : tb
